// >>> design/mbac_pkg.sv
// constants and types shared by the mode-based access checker
package mbac_pkg;

  // ----------------------------------------
  // modes, operations, states
  // ----------------------------------------
  typedef enum logic [1:0] {
    USER_CODE = 2'b00,
    PRIVILEGED_CODE = 2'b01,
    SUPER_SYSTEM_CODE = 2'b10
  } mbac_mode_e;
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_FETCH = 2'b10
  } mbac_op_e;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_ALARM = 1'b1
  } mbac_state_e;

  // ----------------------------------------
  // segment indices
  // ----------------------------------------
  localparam int NUM_SEGS = 8;
  localparam logic [2:0] SEG_PRIVILEGED_ROM_CONSTANTS = 3'h0;
  localparam logic [2:0] SEG_COMMON_ROM_CONSTANTS = 3'h1;
  localparam logic [2:0] SEG_USER_FLASH_CONSTANTS = 3'h2;
  localparam logic [2:0] SEG_ENTRY_VECTOR_TABLE = 3'h3;
  localparam logic [2:0] SEG_PRIVILEGED_CODE_REGION = 3'h4;
  localparam logic [2:0] SEG_COMMON_CODE_REGION = 3'h5;
  localparam logic [2:0] SEG_PRIVILEGED_RAM_REGION = 3'h6;
  localparam logic [2:0] SEG_USER_RAM_REGION = 3'h7;

  // ----------------------------------------
  // register groups: address bits [7:5] group, [4:0] index
  // ----------------------------------------
  localparam logic [2:0] GRP_SYSTEM_MANAGEMENT = 3'h0;
  localparam logic [2:0] GRP_SEGMENT_LAYOUT = 3'h1;
  localparam logic [2:0] GRP_PERMISSION_SETTING = 3'h2;
  localparam logic [2:0] GRP_TEST_REGISTER = 3'h3;
  localparam logic [2:0] GRP_COPROCESSOR_REGISTER = 3'h4;
  localparam logic [5:0] SYS_REG_COUNT = 6'h02;
  localparam logic [5:0] LAYOUT_REG_COUNT = 6'h10;
  localparam logic [5:0] PERM_REG_COUNT = 6'h02;
  localparam logic [5:0] TEST_REG_COUNT = 6'h02;
  localparam logic [5:0] COP_REG_COUNT = 6'h04;
  localparam logic [4:0] SYS_XLATE_OFS = 5'h00;
  localparam logic [4:0] SYS_STATUS_OFS = 5'h01;
  localparam logic [4:0] PERM_SEG_EN_OFS = 5'h00;
  localparam logic [4:0] PERM_GRP_EN_OFS = 5'h01;
  localparam int PERM_TEST_EN_BIT = 0;

  // ----------------------------------------
  // values after reset, counts
  // ----------------------------------------
  localparam logic [15:0] XLATE_RST = 16'h0000;
  localparam logic [7:0] SEG_EN_RST = 8'hFF;
  localparam logic [7:0] GRP_EN_RST = 8'h00;
  localparam logic [15:0] SEG_BASE_RST [0:7] = '{16'h0000, 16'h1000, 16'h2000,
    16'h3000, 16'h3100, 16'h5000, 16'h7000, 16'h8000};
  localparam logic [15:0] SEG_SIZE_RST [0:7] = '{16'h1000, 16'h1000, 16'h1000,
    16'h0100, 16'h1F00, 16'h2000, 16'h1000, 16'h1000};
  localparam logic [2:0] SEC_RESET_HOLD_CYC = 3'h4;

endpackage : mbac_pkg

// >>> design/mbac_seg_window.sv
// address window match for one memory segment
`timescale 1ns/1ns
`default_nettype none
module mbac_seg_window #(
  parameter int AW = 16
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] base,
  input wire logic [AW-1:0] size,
  output logic hit
);
  logic [AW-1:0] offset; // distance above base
  // inside when at or above base and below base plus size
  always_comb begin
    offset = addr - base;
    hit = (addr >= base) && (offset < size);
  end
endmodule : mbac_seg_window
`default_nettype wire

// >>> design/mbac_checker.sv
// mode-based access checker between core, memories and registers
`timescale 1ns/1ns
`default_nettype none
module mbac_checker #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_sfr,
  input wire mbac_pkg::mbac_op_e req_op,
  input wire mbac_pkg::mbac_mode_e req_mode,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic [DW-1:0] mem_rdata,
  output logic req_ready_q,
  output logic mem_valid_q,
  output logic mem_write_q,
  output logic mem_fetch_q,
  output logic [AW-1:0] mem_paddr_q,
  output logic [DW-1:0] mem_wdata_q,
  output logic rsp_valid_q,
  output logic [DW-1:0] rsp_rdata_q,
  output logic viol_q,
  output logic sec_reset_req_q
);
  import mbac_pkg::*;

  // ----------------------------------------
  // permission lookups
  // ----------------------------------------
  // fixed mode/segment/operation table, refusal by default
  function automatic logic seg_grant(mbac_mode_e m, mbac_op_e op, logic [2:0] s);
    logic g;
    g = 1'b0;
    case (m)
      SUPER_SYSTEM_CODE, PRIVILEGED_CODE: begin
        case (s)
          SEG_PRIVILEGED_ROM_CONSTANTS, SEG_COMMON_ROM_CONSTANTS: begin
            g = (op == OP_READ);
          end
          SEG_USER_FLASH_CONSTANTS: begin
            g = (op == OP_READ);
          end
          SEG_ENTRY_VECTOR_TABLE, SEG_PRIVILEGED_CODE_REGION: begin
            g = (op == OP_FETCH);
          end
          SEG_COMMON_CODE_REGION: begin
            g = (op == OP_FETCH);
          end
          SEG_PRIVILEGED_RAM_REGION, SEG_USER_RAM_REGION: begin
            g = (op == OP_READ) || (op == OP_WRITE);
          end
          default: begin
            g = 1'b0;
          end
        endcase
      end
      USER_CODE: begin
        case (s)
          SEG_COMMON_ROM_CONSTANTS, SEG_USER_FLASH_CONSTANTS: begin
            g = (op == OP_READ);
          end
          SEG_COMMON_CODE_REGION: begin
            g = (op == OP_FETCH);
          end
          SEG_USER_RAM_REGION: begin
            g = (op == OP_READ) || (op == OP_WRITE);
          end
          default: begin
            g = 1'b0;
          end
        endcase
      end
      default: begin
        g = 1'b0;
      end
    endcase
    return g;
  endfunction : seg_grant

  // group-level register permission by mode
  function automatic logic grp_grant(mbac_mode_e m, logic [2:0] grp, logic test_en);
    logic g;
    g = 1'b0;
    case (grp)
      GRP_SYSTEM_MANAGEMENT, GRP_SEGMENT_LAYOUT: begin
        g = (m == SUPER_SYSTEM_CODE) || (m == PRIVILEGED_CODE);
      end
      GRP_PERMISSION_SETTING: begin
        g = (m == SUPER_SYSTEM_CODE);
      end
      GRP_TEST_REGISTER: begin
        g = (m == SUPER_SYSTEM_CODE) && test_en;
      end
      GRP_COPROCESSOR_REGISTER: begin
        g = (m == SUPER_SYSTEM_CODE) || (m == PRIVILEGED_CODE) || (m == USER_CODE);
      end
      default: begin
        g = 1'b0;
      end
    endcase
    return g;
  endfunction : grp_grant

  // number of registers present in each group
  function automatic logic [5:0] grp_count(logic [2:0] grp);
    case (grp)
      GRP_SYSTEM_MANAGEMENT: return SYS_REG_COUNT;
      GRP_SEGMENT_LAYOUT: return LAYOUT_REG_COUNT;
      GRP_PERMISSION_SETTING: return PERM_REG_COUNT;
      GRP_TEST_REGISTER: return TEST_REG_COUNT;
      GRP_COPROCESSOR_REGISTER: return COP_REG_COUNT;
      default: return 6'h00;
    endcase
  endfunction : grp_count

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [AW-1:0] xlate_q; // virtual to physical offset
  logic [7:0] viol_cnt_q; // saturating violation count
  logic [AW-1:0] lay_q [0:15]; // base and size per segment
  logic [7:0] seg_en_q; // per-segment enables
  logic [7:0] grp_en_q; // group enables, bit 0 test
  logic [DW-1:0] test_q [0:1]; // test registers
  logic [DW-1:0] cop_q [0:3]; // coprocessor registers
  mbac_state_e state_q; // run or holding reset
  logic [2:0] hold_q; // alarm cycles left
  logic sfr_pend_q; // register answer due next
  logic [DW-1:0] sfr_data_q; // register read data

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  logic take; // request accepted this cycle
  logic take_mem; // accepted memory access
  logic take_sfr; // accepted register access
  logic [NUM_SEGS-1:0] seg_hit; // window matches
  logic any_hit; // address is mapped
  logic [2:0] hit_idx; // lowest matching segment
  logic mem_ok; // memory access granted
  logic [2:0] sfr_grp; // register group
  logic [4:0] sfr_idx; // register index in group
  logic sfr_ok; // register access granted
  logic bad; // violation this cycle
  logic [DW-1:0] sfr_rd; // register read mux

  assign take = req_valid && req_ready_q;
  assign take_mem = take && !req_sfr;
  assign take_sfr = take && req_sfr;
  assign sfr_grp = req_addr[7:5];
  assign sfr_idx = req_addr[4:0];

  // window match on the virtual address for each segment
  for (genvar i = 0; i < NUM_SEGS; i++) begin : g_seg
    mbac_seg_window #(.AW(AW)) u_win (
      .addr(req_addr),
      .base(lay_q[2*i]),
      .size(lay_q[2*i+1]),
      .hit(seg_hit[i])
    );
  end

  // lowest matching segment, then table and enable
  always_comb begin
    hit_idx = 3'h0;
    for (int i = NUM_SEGS - 1; i >= 0; i--) begin
      if (seg_hit[i]) begin
        hit_idx = 3'(i);
      end
    end
    any_hit = |seg_hit;
    mem_ok = any_hit && seg_en_q[hit_idx] && seg_grant(req_mode, req_op, hit_idx);
  end

  // register check: mode permission, register present, no fetch
  always_comb begin
    sfr_ok = grp_grant(req_mode, sfr_grp, grp_en_q[PERM_TEST_EN_BIT])
      && ({1'b0, sfr_idx} < grp_count(sfr_grp))
      && (req_op != OP_FETCH);
  end

  assign bad = (take_mem && !mem_ok) || (take_sfr && !sfr_ok);

  // register read mux
  always_comb begin
    sfr_rd = '0;
    case (sfr_grp)
      GRP_SYSTEM_MANAGEMENT: begin
        sfr_rd = (sfr_idx == SYS_XLATE_OFS) ? DW'(xlate_q) : DW'(viol_cnt_q);
      end
      GRP_SEGMENT_LAYOUT: begin
        sfr_rd = DW'(lay_q[sfr_idx[3:0]]);
      end
      GRP_PERMISSION_SETTING: begin
        sfr_rd = (sfr_idx == PERM_SEG_EN_OFS) ? DW'(seg_en_q) : DW'(grp_en_q);
      end
      GRP_TEST_REGISTER: begin
        sfr_rd = test_q[sfr_idx[0]];
      end
      GRP_COPROCESSOR_REGISTER: begin
        sfr_rd = cop_q[sfr_idx[1:0]];
      end
      default: begin
        sfr_rd = '0;
      end
    endcase
  end

  // ----------------------------------------
  // register writes, one process per group, test and coprocessor sharing one
  // ----------------------------------------
  logic sfr_wr; // granted register write
  assign sfr_wr = take_sfr && sfr_ok && (req_op == OP_WRITE);

  // system management: translation offset, status read-only
  always_ff @(posedge clk) begin
    if (rst) begin
      xlate_q <= AW'(XLATE_RST);
    end else if (sfr_wr && sfr_grp == GRP_SYSTEM_MANAGEMENT && sfr_idx == SYS_XLATE_OFS) begin
      xlate_q <= AW'(req_wdata);
    end
  end

  // segment layout windows
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_SEGS; i++) begin
        lay_q[2*i] <= AW'(SEG_BASE_RST[i]);
        lay_q[2*i+1] <= AW'(SEG_SIZE_RST[i]);
      end
    end else if (sfr_wr && sfr_grp == GRP_SEGMENT_LAYOUT) begin
      lay_q[sfr_idx[3:0]] <= AW'(req_wdata);
    end
  end

  // permission settings
  always_ff @(posedge clk) begin
    if (rst) begin
      seg_en_q <= SEG_EN_RST;
      grp_en_q <= GRP_EN_RST;
    end else if (sfr_wr && sfr_grp == GRP_PERMISSION_SETTING) begin
      if (sfr_idx == PERM_SEG_EN_OFS) begin
        seg_en_q <= req_wdata[7:0];
      end else begin
        grp_en_q <= req_wdata[7:0];
      end
    end
  end

  // test and coprocessor registers
  always_ff @(posedge clk) begin
    if (rst) begin
      test_q <= '{default: '0};
      cop_q <= '{default: '0};
    end else if (sfr_wr && sfr_grp == GRP_TEST_REGISTER) begin
      test_q[sfr_idx[0]] <= req_wdata;
    end else if (sfr_wr && sfr_grp == GRP_COPROCESSOR_REGISTER) begin
      cop_q[sfr_idx[1:0]] <= req_wdata;
    end
  end

  // ----------------------------------------
  // memory side, issued only after the check
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_valid_q <= 1'b0;
      mem_write_q <= 1'b0;
      mem_fetch_q <= 1'b0;
      mem_paddr_q <= '0;
      mem_wdata_q <= '0;
    end else begin
      mem_valid_q <= take_mem && mem_ok;
      mem_write_q <= take_mem && mem_ok && (req_op == OP_WRITE);
      mem_fetch_q <= take_mem && mem_ok && (req_op == OP_FETCH);
      if (take_mem && mem_ok) begin
        mem_paddr_q <= req_addr + xlate_q;
        mem_wdata_q <= req_wdata;
      end
    end
  end

  // ----------------------------------------
  // answers, two cycles after acceptance
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_pend_q <= 1'b0;
      sfr_data_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
    end else begin
      sfr_pend_q <= take_sfr && sfr_ok;
      sfr_data_q <= (req_op == OP_READ) ? sfr_rd : '0;
      rsp_valid_q <= mem_valid_q || sfr_pend_q;
      if (mem_valid_q) begin
        rsp_rdata_q <= mem_write_q ? '0 : mem_rdata;
      end else if (sfr_pend_q) begin
        rsp_rdata_q <= sfr_data_q;
      end else begin
        rsp_rdata_q <= '0;
      end
    end
  end

  // ----------------------------------------
  // violation and reset request
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_RUN;
      hold_q <= '0;
      viol_q <= 1'b0;
      sec_reset_req_q <= 1'b0;
      req_ready_q <= 1'b1;
    end else begin
      viol_q <= bad;
      case (state_q)
        ST_RUN: begin
          if (bad) begin
            state_q <= ST_ALARM;
            hold_q <= SEC_RESET_HOLD_CYC - 3'h1;
            sec_reset_req_q <= 1'b1;
            req_ready_q <= 1'b0;
          end
        end
        ST_ALARM: begin
          if (hold_q == 3'h0) begin
            state_q <= ST_RUN;
            sec_reset_req_q <= 1'b0;
            req_ready_q <= 1'b1;
          end else begin
            hold_q <= hold_q - 3'h1;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // violation count, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      viol_cnt_q <= '0;
    end else if (bad && viol_cnt_q != 8'hFF) begin
      viol_cnt_q <= viol_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_denied;
    take && !(req_sfr ? sfr_ok : mem_ok);
  endsequence
  sequence s_alarm_raised;
    viol_q && sec_reset_req_q && !req_ready_q;
  endsequence

  property p_mem_after_check;
    @(posedge clk) disable iff (rst) mem_valid_q |-> $past(take_mem && mem_ok);
  endproperty
  a_mem_after_check: assert property (p_mem_after_check) else $error("memory issued without grant");

  property p_denied_alarm;
    @(posedge clk) disable iff (rst) s_denied |=> s_alarm_raised;
  endproperty
  a_denied_alarm: assert property (p_denied_alarm) else $error("denial without reset request");

  property p_sfr_missing;
    @(posedge clk) disable iff (rst) (take_sfr && {1'b0, sfr_idx} >= grp_count(sfr_grp)) |=> viol_q;
  endproperty
  a_sfr_missing: assert property (p_sfr_missing) else $error("missing register not flagged");

  property p_hold;
    @(posedge clk) disable iff (rst) $rose(sec_reset_req_q) |-> sec_reset_req_q[*4] ##1 !sec_reset_req_q;
  endproperty
  a_hold: assert property (p_hold) else $error("reset request length wrong");

  property p_no_data;
    @(posedge clk) disable iff (rst) viol_q |=> !rsp_valid_q;
  endproperty
  a_no_data: assert property (p_no_data) else $error("answer after violation");

  property p_translate;
    @(posedge clk) disable iff (rst) mem_valid_q |-> mem_paddr_q == AW'($past(req_addr) + $past(xlate_q));
  endproperty
  a_translate: assert property (p_translate) else $error("wrong physical address");

  property p_user_no_priv_code;
    @(posedge clk) disable iff (rst)
      (take_mem && req_mode == USER_CODE && any_hit && hit_idx == SEG_PRIVILEGED_CODE_REGION) |=> viol_q;
  endproperty
  a_user_no_priv_code: assert property (p_user_no_priv_code) else $error("user reached privileged code");

  property p_super_const_read;
    @(posedge clk) disable iff (rst) (take_mem && req_mode == SUPER_SYSTEM_CODE && req_op == OP_READ
      && any_hit && hit_idx == SEG_PRIVILEGED_ROM_CONSTANTS && seg_en_q[hit_idx]) |=> mem_valid_q ##1 rsp_valid_q;
  endproperty
  a_super_const_read: assert property (p_super_const_read) else $error("super constant read refused");

  property p_priv_vector_fetch;
    @(posedge clk) disable iff (rst) (take_mem && req_mode == PRIVILEGED_CODE && req_op == OP_FETCH
      && any_hit && hit_idx == SEG_ENTRY_VECTOR_TABLE && seg_en_q[hit_idx]) |=> mem_fetch_q && !viol_q;
  endproperty
  a_priv_vector_fetch: assert property (p_priv_vector_fetch) else $error("vector fetch refused");

endmodule : mbac_checker
`default_nettype wire

// >>> tb/mbac_mem_model.sv
// behavioural memory answering granted accesses from the checker
`timescale 1ns/1ns
`default_nettype none
module mbac_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_valid,
  input wire logic [15:0] mem_paddr,
  output logic [15:0] mem_rdata
);
  // ----------------------------------------
  // filler shown while no access is granted
  // ----------------------------------------
  logic [15:0] junk_q; // changes every cycle so stale data never matches
  always_ff @(posedge clk) begin
    if (rst) begin
      junk_q <= 16'hA5A5;
    end else begin
      junk_q <= junk_q + 16'h1357;
    end
  end
  // data follows the address while the access is granted
  assign mem_rdata = mem_valid ? (mem_paddr ^ 16'h5A3C) : junk_q;
endmodule : mbac_mem_model
`default_nettype wire

// >>> tb/mbac_checker_tb_top.sv
// self-checking bench for the mode-based access checker
`timescale 1ns/1ns
`default_nettype none
module mbac_checker_tb_top;
  import mbac_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0; // 100 MHz
  logic rst = 1'b1; // synchronous, high
  logic req_valid = 1'b0;
  logic req_sfr = 1'b0;
  mbac_op_e req_op = OP_READ;
  mbac_mode_e req_mode = USER_CODE;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] mem_rdata;
  logic req_ready_q, mem_valid_q, mem_write_q, mem_fetch_q, rsp_valid_q, viol_q, sec_reset_req_q;
  logic [15:0] mem_paddr_q, mem_wdata_q, rsp_rdata_q;
  int num_errors = 0;
  int check_count = 0;
  int sec_cnt = 0; // length of the current reset request
  integer seed = 37551;
  logic [15:0] xlate = 16'h0000; // offset the bench expects
  logic [33:0] mem_q[$]; // write, fetch, paddr, wdata
  logic [16:0] rsp_q[$]; // violation flag, read data
  // granted segments per mode and operation (read, write, fetch)
  localparam logic [7:0] grant_mask [0:2][0:2] = '{'{8'h86, 8'h80, 8'h20},
    '{8'hC7, 8'hC0, 8'h38}, '{8'hC7, 8'hC0, 8'h38}};

  always #5 clk = ~clk;

  // ----------------------------------------
  // design and memory
  // ----------------------------------------
  mbac_checker dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_sfr(req_sfr), .req_op(req_op),
    .req_mode(req_mode), .req_addr(req_addr), .req_wdata(req_wdata), .mem_rdata(mem_rdata),
    .req_ready_q(req_ready_q), .mem_valid_q(mem_valid_q), .mem_write_q(mem_write_q),
    .mem_fetch_q(mem_fetch_q), .mem_paddr_q(mem_paddr_q), .mem_wdata_q(mem_wdata_q),
    .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .viol_q(viol_q),
    .sec_reset_req_q(sec_reset_req_q));
  mbac_mem_model mem (.clk(clk), .rst(rst), .mem_valid(mem_valid_q), .mem_paddr(mem_paddr_q),
    .mem_rdata(mem_rdata));

  // ----------------------------------------
  // comparison, verdict
  // ----------------------------------------
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // request driver, notes expectations
  // ----------------------------------------
  task automatic issue(input logic sfr, input logic [1:0] op, input logic [1:0] mode,
      input logic [15:0] addr, input logic [15:0] wd, input logic ok, input logic [15:0] rd);
    logic [15:0] pa;
    pa = addr + xlate;
    // gap keeps an earlier answer ahead of the violation
    if (!ok) begin
      req_valid <= 1'b0;
      repeat (2) @(posedge clk);
    end
    req_valid <= 1'b1;
    req_sfr <= sfr;
    req_op <= mbac_op_e'(op);
    req_mode <= mbac_mode_e'(mode);
    req_addr <= addr;
    req_wdata <= wd;
    if (ok && !sfr) mem_q.push_back({op == 2'd1, op == 2'd2, pa, op == 2'd1 ? wd : 16'h0000});
    if (!ok) rsp_q.push_back(17'h10000);
    else if (sfr || op == 2'd1) rsp_q.push_back({1'b0, op == 2'd1 ? 16'h0000 : rd});
    else rsp_q.push_back({1'b0, pa ^ 16'h5A3C});
    @(posedge clk);
    // wait out the reset request before the next one
    if (!ok) begin
      req_valid <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask : issue

  // ----------------------------------------
  // output monitor, pops the oldest note
  // ----------------------------------------
  always @(posedge clk) begin
    #1;
    if (mem_valid_q) begin
      if (mem_q.size() == 0) check("mem_unexpected", 34'h1, 34'h0);
      else check("mem_access", {mem_write_q, mem_fetch_q, mem_paddr_q,
        mem_write_q ? mem_wdata_q : 16'h0000}, mem_q.pop_front());
    end
    if (rsp_valid_q || viol_q) begin
      if (rsp_q.size() == 0) check("rsp_unexpected", 34'h1, 34'h0);
      else check("rsp_or_viol", {viol_q, viol_q ? 16'h0000 : rsp_rdata_q},
        rsp_q.pop_front());
    end
    if (sec_reset_req_q) begin
      sec_cnt++;
    end else if (sec_cnt != 0) begin
      check("sec_hold", sec_cnt, 4);
      sec_cnt = 0;
    end
    if (!rst) check("ready", req_ready_q, !sec_reset_req_q);
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] a;
    logic ok;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // register values after reset, group rights
    issue(1, 0, 2, 16'h0000, 0, 1, XLATE_RST);
    issue(1, 0, 1, 16'h0020, 0, 1, SEG_BASE_RST[0]);
    issue(1, 0, 2, 16'h0021, 0, 1, SEG_SIZE_RST[0]);
    issue(1, 0, 2, 16'h0040, 0, 1, {8'h00, SEG_EN_RST});
    issue(1, 0, 2, 16'h0041, 0, 1, {8'h00, GRP_EN_RST});
    issue(1, 0, 1, 16'h0040, 0, 0, 0);
    issue(1, 0, 2, 16'h0060, 0, 0, 0);
    issue(1, 1, 2, 16'h0041, 16'h0001, 1, 0);
    issue(1, 1, 2, 16'h0061, 16'h1234, 1, 0);
    issue(1, 0, 2, 16'h0061, 0, 1, 16'h1234);
    issue(1, 0, 1, 16'h0061, 0, 0, 0);
    issue(1, 1, 0, 16'h0083, 16'hBEEF, 1, 0);
    issue(1, 0, 0, 16'h0083, 0, 1, 16'hBEEF);
    issue(1, 0, 0, 16'h0000, 0, 0, 0);
    // missing registers, fetch and bad mode
    issue(1, 0, 2, 16'h0005, 0, 0, 0);
    issue(1, 0, 2, 16'h00A0, 0, 0, 0);
    issue(1, 0, 2, 16'h0084, 0, 0, 0);
    issue(1, 2, 2, 16'h0080, 0, 0, 0);
    issue(1, 0, 3, 16'h0080, 0, 0, 0);
    // every mode, operation and segment; reads at the window's top
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 3; o++) begin
        for (int s = 0; s < 8; s++) begin
          a = SEG_BASE_RST[s] + (o == 0 ? SEG_SIZE_RST[s] - 16'h0001 :
            16'($unsigned($random(seed)) % SEG_SIZE_RST[s]));
          ok = (m == 3) ? 1'b0 : grant_mask[m][o][s];
          issue(0, o[1:0], m[1:0], a, 16'($random(seed)), ok, 0);
        end
      end
    end
    issue(0, 0, 2, 16'h9000, 0, 0, 0);
    issue(0, 1, 2, 16'hFFFF, 16'h0F0F, 0, 0);
    // translation offset moves the physical address
    issue(1, 1, 2, 16'h0000, 16'h0100, 1, 0);
    xlate = 16'h0100;
    issue(0, 0, 2, 16'h1010, 0, 1, 0);
    issue(1, 0, 2, 16'h0000, 0, 1, 16'h0100);
    // disabled segment is refused, then restored
    issue(1, 1, 2, 16'h0040, 16'h007F, 1, 0);
    issue(0, 0, 2, 16'h8010, 0, 0, 0);
    issue(1, 1, 2, 16'h0040, 16'h00FF, 1, 0);
    // relocated user ram window
    issue(1, 1, 2, 16'h002E, 16'hA000, 1, 0);
    issue(0, 1, 2, 16'hA010, 16'h5555, 1, 0);
    issue(0, 1, 2, 16'h8010, 16'h5555, 0, 0);
    req_valid <= 1'b0;
    repeat (10) @(posedge clk);
    check("pending", mem_q.size() + rsp_q.size(), 0);
    finish_test();
  end
endmodule : mbac_checker_tb_top
`default_nettype wire
